// ---- rtl/flash_host_ctl.sv ----
// host controller that issues command sequences to a parallel NOR flash
`timescale 1ns/1ps
`default_nettype none
module flash_host_ctl
	import flash_ctl_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// register port
	input wire logic [REG_AW-1:0] regAddr,
	input wire logic [31:0] regWdata,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [31:0] regRdata,
	// flash pins
	output logic [ADDR_W-1:0] flashAddr,
	output logic chipEnable_n,
	output logic outEnable_n,
	output logic writeEnable_n,
	output logic [DATA_W-1:0] dataOut,
	output logic dataOe_n,
	input wire logic [DATA_W-1:0] dataIn
);
	// ****************************************
	// sequencer states
	// ****************************************
	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_LOAD = 3'b001,
		S_ISSUE = 3'b010,
		S_WAIT = 3'b011,
		S_POLL = 3'b100,
		S_POLL_WAIT = 3'b101
	} seq_state_e;

	seq_state_e state_r;
	logic [3:0] op_r;
	logic [ADDR_W-1:0] addr0_r, addr1_r;
	logic [DATA_W-1:0] data0_r, data1_r;
	logic [DATA_W-1:0] rdData_r;
	logic [7:0] fstat_r;
	logic errSeen_r, refused_r;
	logic [1:0] nCyc_r, idx_r;
	logic [1:0] loadIdx_r;
	logic [2:0] loadCnt_r;
	logic lastRead_r, pollAfter_r;
	logic [31:0] regRdata_r;

	flash_cycle_if cyc ();

	// ****************************************
	// command word composition
	// ****************************************
	// low byte carries the code; upper data and address lines are don't care
	function automatic logic [DATA_W-1:0] cmdWord(input logic [7:0] code);
		return {8'h00, code};
	endfunction

	// keep the otp target inside the user words, upper lines zero
	function automatic logic otpAddrOk(input logic [ADDR_W-1:0] a);
		return (a >= OTP_USER_LO) && (a <= OTP_USER_HI);
	endfunction

	logic ctrlWrite, startReq, errBlock, otpBad;
	logic [1:0] opCycles;
	assign ctrlWrite = regWrite && (regAddr == REG_CTRL);
	assign startReq = ctrlWrite && regWdata[8] && (state_r == S_IDLE);
	// once an error is seen only clear status or read ops go out
	assign errBlock = errSeen_r && (regWdata[3:0] != OP_CLEAR)
		&& (regWdata[3:0] != OP_STATUS) && (regWdata[3:0] != OP_READ)
		&& (regWdata[3:0] != OP_ARRAY_RD) && (regWdata[3:0] != OP_POLL);
	assign otpBad = (regWdata[3:0] == OP_OTP_PROG) && !otpAddrOk(addr0_r);

	// number of queued cycles per op, minus one
	always_comb begin
		case (regWdata[3:0])
			OP_WORD_PROG, OP_ERASE, OP_LOCK, OP_STATUS,
			OP_OTP_PROG, OP_OTP_LOCK: opCycles = 2'd1;
			OP_DUAL_PROG: opCycles = 2'd2;
			default: opCycles = 2'd0;
		endcase
	end

	// ****************************************
	// sequence entries per op and slot
	// ****************************************
	logic memWe;
	logic [ADDR_W+DATA_W:0] memWord, memRd;
	logic [3:0] curOp;
	assign curOp = op_r;
	assign memWe = (state_r == S_LOAD);

	always_comb begin
		memWord = {1'b1, {ADDR_W{1'b0}}, cmdWord(CMD_READ_ARRAY)};
		case (curOp)
			// single cycle back to array read
			OP_READ: memWord = {1'b1, {ADDR_W{1'b0}}, cmdWord(CMD_READ_ARRAY)};
			// word program setup then address and data
			OP_WORD_PROG: memWord = (loadIdx_r == 2'd0) ?
				{1'b1, {ADDR_W{1'b0}}, cmdWord(data1_r[0] ? CMD_PROG_ALT : CMD_PROG)} :
				{1'b1, addr0_r, data0_r};
			// dual word, second address differs only in A0
			OP_DUAL_PROG: memWord = (loadIdx_r == 2'd0) ?
				{1'b1, {ADDR_W{1'b0}}, cmdWord(CMD_DUAL_PROG)} :
				(loadIdx_r == 2'd1) ? {1'b1, addr0_r, data0_r} :
				{1'b1, addr0_r[ADDR_W-1:1], ~addr0_r[0], data1_r};
			// erase setup, confirm at any word of the sector
			OP_ERASE: memWord = (loadIdx_r == 2'd0) ?
				{1'b1, {ADDR_W{1'b0}}, cmdWord(CMD_ERASE_SETUP)} :
				{1'b1, addr0_r, cmdWord(CMD_CONFIRM)};
			// suspend and resume are single codes
			OP_SUSPEND: memWord = {1'b1, {ADDR_W{1'b0}}, cmdWord(CMD_SUSPEND)};
			OP_RESUME: memWord = {1'b1, {ADDR_W{1'b0}}, cmdWord(CMD_CONFIRM)};
			OP_ID: memWord = {1'b1, {ADDR_W{1'b0}}, cmdWord(CMD_ID_MODE)};
			// lock setup then action code at the sector
			OP_LOCK: memWord = (loadIdx_r == 2'd0) ?
				{1'b1, {ADDR_W{1'b0}}, cmdWord(CMD_LOCK_SETUP)} :
				{1'b1, addr0_r, cmdWord(data0_r[7:0])};
			// status command then a read anywhere
			OP_STATUS: memWord = (loadIdx_r == 2'd0) ?
				{1'b1, {ADDR_W{1'b0}}, cmdWord(CMD_READ_STATUS)} :
				{1'b0, {ADDR_W{1'b0}}, {DATA_W{1'b0}}};
			// only this code clears the sticky errors
			OP_CLEAR: memWord = {1'b1, {ADDR_W{1'b0}}, cmdWord(CMD_CLEAR_STATUS)};
			// otp setup then data at target word
			OP_OTP_PROG: memWord = (loadIdx_r == 2'd0) ?
				{1'b1, {ADDR_W{1'b0}}, cmdWord(CMD_OTP_SETUP)} :
				{1'b1, addr0_r, data0_r};
			// lock user otp block for good
			OP_OTP_LOCK: memWord = (loadIdx_r == 2'd0) ?
				{1'b1, {ADDR_W{1'b0}}, cmdWord(CMD_OTP_SETUP)} :
				{1'b1, OTP_LOCK_ADDR, OTP_LOCK_DATA};
			OP_QUERY: memWord = {1'b1, {ADDR_W{1'b0}}, cmdWord(CMD_QUERY)};
			// plain read at addr0, used for array, id, lock flag and query data
			OP_ARRAY_RD: memWord = {1'b0, addr0_r, {DATA_W{1'b0}}};
			OP_POLL: memWord = {1'b0, {ADDR_W{1'b0}}, {DATA_W{1'b0}}};
			default: memWord = {1'b1, {ADDR_W{1'b0}}, cmdWord(CMD_READ_ARRAY)};
		endcase
	end

	flash_seq_mem u_mem (
		.ref_clk(ref_clk),
		.wrEn(memWe),
		.wrIdx(loadIdx_r),
		.wrWord(memWord),
		.rdIdx(idx_r),
		.rdWord(memRd)
	);

	flash_bus_cycle u_cyc (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.cyc(cyc),
		.flashAddr(flashAddr),
		.chipEnable_n(chipEnable_n),
		.outEnable_n(outEnable_n),
		.writeEnable_n(writeEnable_n),
		.dataOut(dataOut),
		.dataOe_n(dataOe_n),
		.dataIn(dataIn)
	);

	// ****************************************
	// cycle request to the engine
	// ****************************************
	assign cyc.start = (state_r == S_ISSUE) || (state_r == S_POLL);
	assign cyc.isWrite = (state_r == S_ISSUE) && memRd[ADDR_W+DATA_W];
	assign cyc.addr = (state_r == S_POLL) ? {ADDR_W{1'b0}} : memRd[ADDR_W+DATA_W-1:DATA_W];
	assign cyc.wdata = memRd[DATA_W-1:0];

	// command writes sample a floating bus, so only a read may update status
	logic cycIsRead;
	assign cycIsRead = !memRd[ADDR_W+DATA_W];

	logic programOp;
	assign programOp = (op_r == OP_WORD_PROG) || (op_r == OP_DUAL_PROG)
		|| (op_r == OP_ERASE) || (op_r == OP_OTP_PROG) || (op_r == OP_OTP_LOCK);

	// ****************************************
	// sequencer
	// ****************************************
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			state_r <= S_IDLE;
			op_r <= OP_READ;
			nCyc_r <= 2'd0;
			idx_r <= 2'd0;
			loadIdx_r <= 2'd0;
			loadCnt_r <= 3'd0;
			lastRead_r <= 1'b0;
			pollAfter_r <= 1'b0;
			refused_r <= 1'b0;
			errSeen_r <= 1'b0;
			rdData_r <= '0;
			fstat_r <= 8'h00;
		end else begin
			case (state_r)
				S_IDLE: begin
					if (startReq) begin
						refused_r <= errBlock || otpBad;
						if (!errBlock && !otpBad) begin
							op_r <= regWdata[3:0];
							nCyc_r <= opCycles;
							pollAfter_r <= regWdata[9];
							loadIdx_r <= 2'd0;
							loadCnt_r <= {1'b0, opCycles} + 3'd1;
							state_r <= S_LOAD;
						end
					end
				end
				S_LOAD: begin
					loadIdx_r <= loadIdx_r + 2'd1;
					loadCnt_r <= loadCnt_r - 3'd1;
					if (loadCnt_r == 3'd1) begin
						idx_r <= 2'd0;
						state_r <= S_WAIT;
						lastRead_r <= 1'b1;
					end
				end
				S_ISSUE: begin
					// engine takes the request on this edge
					state_r <= S_WAIT;
				end
				S_WAIT: begin
					// one cycle for the registered memory read
					if (lastRead_r) begin
						lastRead_r <= 1'b0;
						state_r <= S_ISSUE;
					end else if (cyc.done) begin
						rdData_r <= cyc.rdata;
						if ((op_r == OP_STATUS || op_r == OP_POLL) && cycIsRead) begin
							fstat_r <= cyc.rdata[7:0];
							// any error bit marks the host as needing a clear
							if (cyc.rdata[SB_RANGE] || cyc.rdata[SB_PROG]
								|| cyc.rdata[SB_LOCK]) begin
								errSeen_r <= 1'b1;
							end
						end
						if (op_r == OP_CLEAR) begin
							errSeen_r <= 1'b0;
						end
						if (idx_r == nCyc_r) begin
							// polling is optional, and only after a program, erase or otp op
							state_r <= (pollAfter_r && programOp) ? S_POLL : S_IDLE;
						end else begin
							idx_r <= idx_r + 2'd1;
							lastRead_r <= 1'b1;
						end
					end
				end
				S_POLL: begin
					state_r <= S_POLL_WAIT;
				end
				S_POLL_WAIT: begin
					if (cyc.done) begin
						fstat_r <= cyc.rdata[7:0];
						// a fresh read each time until the ready bit is 1
						if (cyc.rdata[SB_READY]) begin
							if (cyc.rdata[SB_RANGE] || cyc.rdata[SB_PROG]
								|| cyc.rdata[SB_LOCK]) begin
								errSeen_r <= 1'b1;
							end
							state_r <= S_IDLE;
						end else begin
							state_r <= S_POLL;
						end
					end
				end
				default: state_r <= S_IDLE;
			endcase
		end
	end

	// ****************************************
	// register file
	// ****************************************
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			addr0_r <= '0;
			data0_r <= '0;
			addr1_r <= '0;
			data1_r <= '0;
		end else if (regWrite) begin
			if (regAddr == REG_ADDR0) begin
				addr0_r <= regWdata[ADDR_W-1:0];
			end else if (regAddr == REG_DATA0) begin
				data0_r <= regWdata[DATA_W-1:0];
			end else if (regAddr == REG_ADDR1) begin
				addr1_r <= regWdata[ADDR_W-1:0];
			end else if (regAddr == REG_DATA1) begin
				data1_r <= regWdata[DATA_W-1:0];
			end
		end
	end

	logic [31:0] rdMux;
	logic busy;
	assign busy = (state_r != S_IDLE);
	// read decode; unmapped offsets return zero
	assign rdMux = (regAddr == REG_CTRL) ? {28'h000_0000, op_r} :
		(regAddr == REG_ADDR0) ? {12'h000, addr0_r} :
		(regAddr == REG_DATA0) ? {16'h0000, data0_r} :
		(regAddr == REG_ADDR1) ? {12'h000, addr1_r} :
		(regAddr == REG_DATA1) ? {16'h0000, data1_r} :
		(regAddr == REG_STATE) ? {29'h000_0000, refused_r, errSeen_r, busy} :
		(regAddr == REG_RDATA) ? {16'h0000, rdData_r} :
		(regAddr == REG_FSTAT) ? {24'h00_0000, fstat_r} : RESET_WORD;

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			regRdata_r <= RESET_WORD;
		end else begin
			regRdata_r <= regRead ? rdMux : RESET_WORD;
		end
	end
	assign regRdata = regRdata_r;
endmodule
`default_nettype wire

// ---- rtl/flash_ctl_pkg.sv ----
// constants, command codes and register map of the parallel flash command controller
package flash_ctl_pkg;
	// ****************************************
	// bus widths
	// ****************************************
	localparam int ADDR_W = 20;
	localparam int DATA_W = 16;
	localparam int REG_AW = 4;
	localparam int SEQ_DEPTH = 4;

	// ****************************************
	// command codes
	// ****************************************
	localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
	localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
	localparam logic [7:0] CMD_CONFIRM = 8'hD0;
	localparam logic [7:0] CMD_PROG = 8'h40;
	localparam logic [7:0] CMD_PROG_ALT = 8'h10;
	localparam logic [7:0] CMD_DUAL_PROG = 8'hE0;
	localparam logic [7:0] CMD_SUSPEND = 8'hB0;
	localparam logic [7:0] CMD_ID_MODE = 8'h90;
	localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;
	localparam logic [7:0] CMD_SOFT_LOCK = 8'h01;
	localparam logic [7:0] CMD_HARD_LOCK = 8'h2F;
	localparam logic [7:0] CMD_READ_STATUS = 8'h70;
	localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
	localparam logic [7:0] CMD_OTP_SETUP = 8'hC0;
	localparam logic [7:0] CMD_QUERY = 8'h98;
	localparam logic [15:0] OTP_LOCK_DATA = 16'hFFFD;
	localparam logic [19:0] OTP_LOCK_ADDR = 20'h0_0080;
	localparam logic [19:0] OTP_USER_LO = 20'h0_0085;
	localparam logic [19:0] OTP_USER_HI = 20'h0_0088;

	// ****************************************
	// status bit positions
	// ****************************************
	localparam int SB_LOCK = 1;
	localparam int SB_RANGE = 3;
	localparam int SB_PROG = 4;
	localparam int SB_PAUSED = 6;
	localparam int SB_READY = 7;
	localparam int LOCK_FLAG_BIT = 1;

	// ****************************************
	// operation selectors written to the op register
	// ****************************************
	localparam logic [3:0] OP_READ = 4'h0;
	localparam logic [3:0] OP_WORD_PROG = 4'h1;
	localparam logic [3:0] OP_DUAL_PROG = 4'h2;
	localparam logic [3:0] OP_ERASE = 4'h3;
	localparam logic [3:0] OP_SUSPEND = 4'h4;
	localparam logic [3:0] OP_RESUME = 4'h5;
	localparam logic [3:0] OP_ID = 4'h6;
	localparam logic [3:0] OP_LOCK = 4'h7;
	localparam logic [3:0] OP_STATUS = 4'h8;
	localparam logic [3:0] OP_CLEAR = 4'h9;
	localparam logic [3:0] OP_OTP_PROG = 4'hA;
	localparam logic [3:0] OP_OTP_LOCK = 4'hB;
	localparam logic [3:0] OP_QUERY = 4'hC;
	localparam logic [3:0] OP_ARRAY_RD = 4'hD;
	localparam logic [3:0] OP_POLL = 4'hE;

	// ****************************************
	// register offsets and reset values
	// ****************************************
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_ADDR0 = 4'h1;
	localparam logic [3:0] REG_DATA0 = 4'h2;
	localparam logic [3:0] REG_ADDR1 = 4'h3;
	localparam logic [3:0] REG_DATA1 = 4'h4;
	localparam logic [3:0] REG_STATE = 4'h5;
	localparam logic [3:0] REG_RDATA = 4'h6;
	localparam logic [3:0] REG_FSTAT = 4'h7;
	localparam logic [31:0] RESET_WORD = 32'h0000_0000;

	// ****************************************
	// bus cycle timing, in ns and cycles
	// ****************************************
	localparam int CLK_NS = 8;
	localparam int T_SETUP_NS = 20;
	localparam int T_STROBE_NS = 70;
	localparam int T_RECOVER_NS = 20;
	localparam logic [3:0] SETUP_CYC = 4'((T_SETUP_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [3:0] STROBE_CYC = 4'((T_STROBE_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [3:0] RECOVER_CYC = 4'((T_RECOVER_NS + CLK_NS - 1) / CLK_NS);
endpackage

// ---- rtl/flash_cycle_if.sv ----
// interface between the sequencer and the bus cycle engine
`timescale 1ns/1ps
`default_nettype none
interface flash_cycle_if;
	import flash_ctl_pkg::*;
	logic start;
	logic isWrite;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata;
	logic done;
	logic [DATA_W-1:0] rdata;
	modport master (output start, output isWrite, output addr, output wdata,
		input done, input rdata);
	modport engine (input start, input isWrite, input addr, input wdata,
		output done, output rdata);
endinterface
`default_nettype wire

// ---- rtl/flash_seq_mem.sv ----
// small memory holding the queued bus cycles of one command sequence
`timescale 1ns/1ps
`default_nettype none
module flash_seq_mem
	import flash_ctl_pkg::*;
(
	// clock
	input wire logic ref_clk,
	// write port
	input wire logic wrEn,
	input wire logic [1:0] wrIdx,
	input wire logic [ADDR_W+DATA_W:0] wrWord,
	// read port
	input wire logic [1:0] rdIdx,
	output logic [ADDR_W+DATA_W:0] rdWord
);
	logic [ADDR_W+DATA_W:0] mem [SEQ_DEPTH];

	// registered read keeps the pin path free of the array decode
	always_ff @(posedge ref_clk) begin
		if (wrEn) begin
			mem[wrIdx] <= wrWord;
		end
		rdWord <= mem[rdIdx];
	end
endmodule
`default_nettype wire

// ---- rtl/flash_bus_cycle.sv ----
// bus cycle engine: drives one write or read strobe on the flash pins
`timescale 1ns/1ps
`default_nettype none
module flash_bus_cycle
	import flash_ctl_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// sequencer side
	flash_cycle_if.engine cyc,
	// flash pins
	output logic [ADDR_W-1:0] flashAddr,
	output logic chipEnable_n,
	output logic outEnable_n,
	output logic writeEnable_n,
	output logic [DATA_W-1:0] dataOut,
	output logic dataOe_n,
	input wire logic [DATA_W-1:0] dataIn
);
	typedef enum logic [1:0] {
		C_IDLE = 2'b00,
		C_SETUP = 2'b01,
		C_STROBE = 2'b10,
		C_RECOVER = 2'b11
	} cyc_state_e;
	cyc_state_e state_r;
	logic [3:0] cnt_r;
	logic wr_r;
	logic [DATA_W-1:0] sync1_r, sync2_r;
	logic cntZero;
	assign cntZero = (cnt_r == 4'h0);

	// pin data passes two flops before capture
	always_ff @(posedge ref_clk) begin
		sync1_r <= dataIn;
		sync2_r <= sync1_r;
	end

	// every cycle asserts chip enable anew, so status refreshes on each read
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			state_r <= C_IDLE;
			cnt_r <= 4'h0;
			wr_r <= 1'b0;
			flashAddr <= '0;
			dataOut <= '0;
			chipEnable_n <= 1'b1;
			outEnable_n <= 1'b1;
			writeEnable_n <= 1'b1;
			dataOe_n <= 1'b1;
			cyc.rdata <= '0;
			cyc.done <= 1'b0;
		end else begin
			cyc.done <= 1'b0;
			case (state_r)
				C_IDLE: begin
					if (cyc.start) begin
						flashAddr <= cyc.addr;
						dataOut <= cyc.wdata;
						wr_r <= cyc.isWrite;
						dataOe_n <= ~cyc.isWrite;
						chipEnable_n <= 1'b0;
						cnt_r <= SETUP_CYC;
						state_r <= C_SETUP;
					end
				end
				C_SETUP: begin
					cnt_r <= cnt_r - 4'h1;
					if (cntZero) begin
						writeEnable_n <= ~wr_r;
						outEnable_n <= wr_r;
						cnt_r <= STROBE_CYC;
						state_r <= C_STROBE;
					end
				end
				C_STROBE: begin
					cnt_r <= cnt_r - 4'h1;
					if (cntZero) begin
						// two extra sync cycles are inside the strobe budget margin
						cyc.rdata <= sync2_r;
						writeEnable_n <= 1'b1;
						outEnable_n <= 1'b1;
						cnt_r <= RECOVER_CYC;
						state_r <= C_RECOVER;
					end
				end
				C_RECOVER: begin
					cnt_r <= cnt_r - 4'h1;
					if (cntZero) begin
						chipEnable_n <= 1'b1;
						dataOe_n <= 1'b1;
						cyc.done <= 1'b1;
						state_r <= C_IDLE;
					end
				end
				default: state_r <= C_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

// ---- bench/flash_host_ctl_assertions.sv ----
// pin protocol checker for the flash command controller
`timescale 1ns/1ps
`default_nettype none
module flash_host_ctl_assertions
	import flash_ctl_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// register port
	input wire logic [REG_AW-1:0] regAddr,
	input wire logic [31:0] regWdata,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [31:0] regRdata,
	// flash pins
	input wire logic [ADDR_W-1:0] flashAddr,
	input wire logic chipEnable_n,
	input wire logic outEnable_n,
	input wire logic writeEnable_n,
	input wire logic [DATA_W-1:0] dataOut,
	input wire logic dataOe_n,
	input wire logic [DATA_W-1:0] dataIn
);
	// *****
	// bus cycle shape
	// *****
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (sys_rst);
	strobe_exclusive_a: assert property (!(!writeEnable_n && !outEnable_n))
		else $error("both strobes low");
	write_drives_bus_a: assert property (!writeEnable_n |-> !chipEnable_n && !dataOe_n)
		else $error("write strobe without chip enable or data");
	read_bus_free_a: assert property (!outEnable_n |-> dataOe_n && !chipEnable_n)
		else $error("read strobe while driving data");
	write_width_a: assert property ($fell(writeEnable_n) |-> !writeEnable_n [*8])
		else $error("write strobe too short");
	write_setup_a: assert property ($fell(writeEnable_n) |-> $past(chipEnable_n, 3) == 1'b0)
		else $error("chip enable setup short");
	cmd_hold_a: assert property (!writeEnable_n && !$past(writeEnable_n) |->
		$stable(flashAddr) && $stable(dataOut)) else $error("address or data moved in strobe");
	ce_recover_a: assert property ($rose(writeEnable_n) |-> !chipEnable_n [*4])
		else $error("chip enable released too early");
	rdata_slot_a: assert property (!$past(regRead) |-> regRdata == 32'h0000_0000)
		else $error("read data outside its slot");
	idle_pins_a: assert property (chipEnable_n |-> writeEnable_n && outEnable_n && dataOe_n)
		else $error("strobe or bus active while deselected");
	// main traffic seen
	cover property ($fell(writeEnable_n));
	cover property ($fell(outEnable_n));
	cover property (regRead ##1 regRdata != 32'h0000_0000);
endmodule
bind flash_host_ctl flash_host_ctl_assertions chk (.ref_clk, .sys_rst, .regAddr, .regWdata,
	.regWrite, .regRead, .regRdata, .flashAddr, .chipEnable_n, .outEnable_n, .writeEnable_n,
	.dataOut, .dataOe_n, .dataIn);
`default_nettype wire

// ---- bench/flash_dev_model.sv ----
// behavioural model of the parallel NOR flash behind the controller
`timescale 1ns/1ps
`default_nettype none
module flash_dev_model
	import flash_ctl_pkg::*;
#(
	parameter logic [15:0] MAKER_ID = 16'h00A5, // arbitrary value
	parameter logic [15:0] PART_ID = 16'h005A, // arbitrary value
	parameter int PROG_NS = 400,
	parameter int ERASE_NS = 3000
)(
	// flash pins
	input wire logic [ADDR_W-1:0] flashAddr,
	input wire logic chipEnable_n,
	input wire logic outEnable_n,
	input wire logic writeEnable_n,
	input wire logic [DATA_W-1:0] dataOut,
	output logic [DATA_W-1:0] dataIn,
	// fault controls
	input wire logic supplyLow,
	input wire logic failProg
);
	logic [15:0] mem [int];
	logic [15:0] otp [16];
	logic [15:0] lastWord;
	logic [7:0] pend, nxt;
	logic [1:0] mode;
	logic lockAbort, rangeErr, progErr, paused, otpLocked;
	time busyUntil;
	initial begin
		{pend, mode, lockAbort, rangeErr, progErr, paused, otpLocked} = '0;
		busyUntil = 0;
		dataIn = 16'h5A5A;
	end
	task automatic doProg(input bit toOtp);
		if (rangeErr) return;
		if (supplyLow) {rangeErr, progErr} = 2'b11;
		else if (failProg) progErr = 1'b1;
		else if (toOtp) otp[flashAddr[3:0]] = dataOut;
		else mem[flashAddr] = dataOut;
		busyUntil = $time + PROG_NS;
		mode = 2'd1;
	endtask
	always @(posedge writeEnable_n) if (!chipEnable_n) begin
		lastWord = dataOut;
		nxt = 8'h00;
		case (pend)
			8'hC0: if (flashAddr == 20'h0_0080 && dataOut == 16'hFFFD) {otpLocked, mode} = 3'b101;
				else if (flashAddr < 20'h0_0085 || flashAddr > 20'h0_0088) {progErr, mode} = 3'b101;
				else if (otpLocked) {lockAbort, progErr, mode} = 4'b1101;
				else doProg(1'b1);
			8'h40, 8'h10, 8'hE1: doProg(1'b0);
			8'hE0: begin
				mem[flashAddr] = dataOut;
				nxt = 8'hE1;
			end
			8'h20: if (dataOut[7:0] == 8'hD0) begin
				busyUntil = $time + ERASE_NS;
				mode = 2'd1;
			end
			8'h60: nxt = 8'h00;
			default: case (dataOut[7:0])
				8'hFF, 8'h98: mode = 2'd0;
				8'h70: mode = 2'd1;
				8'h90: mode = 2'd2;
				8'h50: {lockAbort, rangeErr, progErr} = 3'b000;
				8'hB0: paused = $time < busyUntil;
				8'hD0: if (paused) begin
					paused = 1'b0;
					busyUntil = $time + ERASE_NS;
				end
				default: nxt = dataOut[7:0];
			endcase
		endcase
		pend = nxt;
	end
	// status refreshed per strobe; released bus flips
	always @(chipEnable_n or outEnable_n or flashAddr) begin
		if (!chipEnable_n && !outEnable_n) begin
			if (mode == 2'd1) dataIn = {8'h00, ($time >= busyUntil) || paused, paused, 1'b0,
				progErr, rangeErr, 1'b0, lockAbort, 1'b0};
			else if (mode == 2'd2) dataIn = flashAddr == 20'h0 ? MAKER_ID :
				flashAddr == 20'h1 ? PART_ID :
				flashAddr == 20'h0_0080 ? {14'h0, !otpLocked, 1'b0} : otp[flashAddr[3:0]];
			else dataIn = mem.exists(flashAddr) ? mem[flashAddr] : 16'hFFFF;
		end else begin
			dataIn = ~dataIn;
		end
	end
endmodule
`default_nettype wire

// ---- bench/tb.sv ----
// self-checking bench for the flash command controller
`timescale 1ns/1ps
`default_nettype none
module tb;
	import flash_ctl_pkg::*;
	logic refClk, sysRst, regWrite, regRead, supplyLow, failProg;
	logic [3:0] regAddr;
	logic [31:0] regWdata, regRdata, rd;
	logic [19:0] flashAddr;
	logic chipEnable_n, outEnable_n, writeEnable_n, dataOe_n;
	logic [15:0] dataOut, dataIn;
	int failCount, checksDone;
	logic [3:0] opTab [6] = '{OP_READ, OP_SUSPEND, OP_RESUME, OP_ID, OP_CLEAR, OP_QUERY};
	logic [7:0] codeTab [6] = '{8'hFF, 8'hB0, 8'hD0, 8'h90, 8'h50, 8'h98};
	logic [7:0] lockTab [3] = '{8'h01, 8'h2F, 8'hD0};
	// *****
	// design and far side
	// *****
	flash_host_ctl dut (.ref_clk(refClk), .sys_rst(sysRst), .regAddr(regAddr),
		.regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
		.flashAddr(flashAddr), .chipEnable_n(chipEnable_n), .outEnable_n(outEnable_n),
		.writeEnable_n(writeEnable_n), .dataOut(dataOut), .dataOe_n(dataOe_n), .dataIn(dataIn));
	flash_dev_model fm (.flashAddr(flashAddr), .chipEnable_n(chipEnable_n),
		.outEnable_n(outEnable_n), .writeEnable_n(writeEnable_n), .dataOut(dataOut),
		.dataIn(dataIn), .supplyLow(supplyLow), .failProg(failProg));
	// 8 ns clock
	initial begin
		refClk = 1'b0;
		forever #4 refClk = ~refClk;
	end
	// register port cycles
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge refClk);
		regAddr <= a;
		regWdata <= d;
		regWrite <= 1'b1;
		@(posedge refClk);
		regWrite <= 1'b0;
	endtask
	task automatic rdReg(input logic [3:0] a);
		@(posedge refClk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge refClk);
		regRead <= 1'b0;
		#1 rd = regRdata;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checksDone++;
		if (got !== exp) begin
			failCount++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// one operation; leaves the final state word in rd
	task automatic run(input logic [3:0] op, input logic [19:0] a, input logic [15:0] d,
		input logic poll);
		wr(REG_ADDR0, {12'h000, a});
		wr(REG_DATA0, {16'h0000, d});
		wr(REG_CTRL, {22'h0, poll, 1'b1, 4'h0, op});
		rdReg(REG_STATE);
		for (int i = 0; i < 400 && rd[0] === 1'b1; i++) rdReg(REG_STATE);
		chk(rd & 32'h1, 32'h0);
	endtask
	task automatic readAt(input logic [19:0] a);
		run(OP_ARRAY_RD, a, 16'h0000, 1'b0);
		rdReg(REG_RDATA);
	endtask
	task automatic giveVerdict();
		$display("checks %0d mismatches %0d", checksDone, failCount);
		if (failCount == 0 && checksDone > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// watchdog
	initial begin
		#500us;
		failCount++;
		giveVerdict();
	end
	// test sequence
	initial begin
		{regWrite, regRead, supplyLow, failProg, regAddr, regWdata} = '0;
		failCount = 0;
		checksDone = 0;
		sysRst = 1'b1;
		repeat (12) @(posedge refClk);
		sysRst <= 1'b0;
		rdReg(REG_STATE);
		chk(rd, RESET_WORD);
		foreach (opTab[i]) begin
			run(opTab[i], 20'hF_FF00, 16'h0000, 1'b0);
			chk({16'h0, fm.lastWord}, {24'h0, codeTab[i]});
		end
		foreach (lockTab[i]) begin
			run(OP_LOCK, 20'h4_8123, {8'h00, lockTab[i]}, 1'b0);
			chk({16'h0, fm.lastWord}, {24'h0, lockTab[i]});
		end
		$display("test codes done");
		wr(REG_DATA1, 32'h0000_0001);
		run(OP_WORD_PROG, 20'h1_2346, 16'hCAFE, 1'b1);
		rdReg(REG_FSTAT);
		chk(rd, 32'h0000_0080);
		run(OP_READ, 20'h0_0000, 16'h0000, 1'b0);
		readAt(20'h1_2346);
		chk(rd, 32'h0000_CAFE);
		wr(REG_DATA1, 32'h0000_5678);
		run(OP_DUAL_PROG, 20'h0_0100, 16'h1234, 1'b1);
		chk({16'h0, fm.mem[257]}, 32'h0000_5678);
		$display("test program done");
		run(OP_OTP_PROG, 20'h0_0085, 16'h1357, 1'b1);
		run(OP_ID, 20'h0_0000, 16'h0000, 1'b0);
		readAt(20'h0_0085);
		chk(rd, 32'h0000_1357);
		readAt(20'h0_0000);
		chk(rd, 32'h0000_00A5);
		readAt(20'h0_0080);
		chk(rd & 32'h2, 32'h2);
		run(OP_OTP_LOCK, 20'h0_0000, 16'h0000, 1'b1);
		chk({16'h0, fm.lastWord}, 32'h0000_FFFD);
		run(OP_ID, 20'h0_0000, 16'h0000, 1'b0);
		readAt(20'h0_0080);
		chk(rd & 32'h2, 32'h0);
		$display("test otp done");
		run(OP_OTP_PROG, 20'h0_0086, 16'h2468, 1'b1);
		rdReg(REG_FSTAT);
		chk(rd & 32'h9A, 32'h92);
		run(OP_WORD_PROG, 20'h0_0200, 16'h1111, 1'b1);
		chk(rd & 32'h7, 32'h6);
		run(OP_READ, 20'h0_0000, 16'h0000, 1'b0);
		run(OP_STATUS, 20'h0_0000, 16'h0000, 1'b0);
		rdReg(REG_RDATA);
		chk(rd & 32'h1A, 32'h12);
		run(OP_CLEAR, 20'h0_0000, 16'h0000, 1'b0);
		run(OP_STATUS, 20'h0_0000, 16'h0000, 1'b0);
		rdReg(REG_RDATA);
		chk(rd & 32'h1A, 32'h0);
		supplyLow <= 1'b1;
		run(OP_WORD_PROG, 20'h0_0300, 16'h2222, 1'b1);
		rdReg(REG_FSTAT);
		chk(rd & 32'h9A, 32'h98);
		supplyLow <= 1'b0;
		run(OP_CLEAR, 20'h0_0000, 16'h0000, 1'b0);
		failProg <= 1'b1;
		run(OP_WORD_PROG, 20'h0_0301, 16'h3333, 1'b1);
		rdReg(REG_FSTAT);
		chk(rd & 32'h9A, 32'h90);
		failProg <= 1'b0;
		run(OP_CLEAR, 20'h0_0000, 16'h0000, 1'b0);
		$display("test errors done");
		run(OP_OTP_PROG, 20'h0_0084, 16'h4444, 1'b1);
		chk(rd & 32'h4, 32'h4);
		run(OP_OTP_PROG, 20'h1_0085, 16'h4444, 1'b1);
		chk(rd & 32'h4, 32'h4);
		$display("test range done");
		run(OP_ERASE, 20'h0_8ABC, 16'h0000, 1'b0);
		chk({16'h0, fm.lastWord}, 32'h0000_00D0);
		run(OP_STATUS, 20'h0_0000, 16'h0000, 1'b0);
		rdReg(REG_RDATA);
		chk(rd & 32'hC0, 32'h00);
		run(OP_SUSPEND, 20'h0_0000, 16'h0000, 1'b0);
		run(OP_STATUS, 20'h0_0000, 16'h0000, 1'b0);
		rdReg(REG_RDATA);
		chk(rd & 32'hC0, 32'hC0);
		run(OP_RESUME, 20'h0_0000, 16'h0000, 1'b0);
		run(OP_STATUS, 20'h0_0000, 16'h0000, 1'b0);
		rdReg(REG_RDATA);
		chk(rd & 32'hC0, 32'h00);
		run(OP_POLL, 20'h0_0000, 16'h0000, 1'b0);
		rdReg(REG_FSTAT);
		chk(rd & 32'hC0, 32'h00);
		$display("test erase done");
		giveVerdict();
	end
endmodule
`default_nettype wire
